// ===== core/cssp_port.sv
/*
  Clocked serial shift port: 8-bit shift register, octal bit counter,
  internal clock generator and a classic Wishbone register slave.
  Assumes all pin inputs synchronous to mclk and one instruction cycle
  equal to one mclk cycle.
*/
`timescale 1ns/1ps
module cssp_port
(
  // Clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [11:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Shared port bit / serial clock pin
  input  wire logic                sck_in,
  // Serial data input pin
  input  wire logic                si_in,
  // Serial clock and data output pins
  output cssp_pkg::cssp_pins_t     pins,
  // Serial interrupt request flag
  output logic                     serial_irq
);

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  cssp_pkg::cssp_state_t state;
  cssp_pkg::cssp_mode_t  mode;
  cssp_pkg::cssp_mode_t  mode_pend;
  logic [1:0]            mode_dly;
  logic [1:0]            port_mode_a;
  logic                  port_out;
  logic                  port_dir;
  logic [2:0]            bit_count;
  logic [7:0]            shift_reg;
  logic                  so_q;
  logic                  sck_int;
  logic [11:0]           half_cnt;
  logic [11:0]           half_sel;
  logic                  gen_run;
  logic                  sck_prev;
  logic                  req;
  logic                  wr;
  logic [9:0]            idx;
  logic                  mode_wr;
  logic                  start_cmd;
  logic                  clear_cmd;
  logic                  pm_change;
  logic                  ext_sel;
  logic                  serial_on;
  logic                  shifting;
  logic                  cont_active;
  logic                  gen_tick;
  logic                  sck_fall;
  logic                  sck_rise;
  logic                  wrap;
  logic                  abort;
  logic [31:0]           next_dat;

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = req & wb_we_i & wb_sel_i[0];
  assign idx       = wb_adr_i[11:2];
  assign mode_wr   = wr & (idx == cssp_pkg::IDX_MODE);
  assign start_cmd = wr & (idx == cssp_pkg::IDX_CTRL)
                   & wb_dat_i[cssp_pkg::CTRL_START_BIT];
  assign clear_cmd = wr & (idx == cssp_pkg::IDX_CTRL)
                   & wb_dat_i[cssp_pkg::CTRL_CLEAR_BIT];
  assign pm_change = wr & (idx == cssp_pkg::IDX_PORT_MODE)
                   & (wb_dat_i[1:0] != port_mode_a);

  //--------------------------------------------------------------------
  // Mode decode
  //--------------------------------------------------------------------
  // pin function and mode
  assign serial_on   = mode.pin_function_bit;
  assign ext_sel     = mode.clock_select == cssp_pkg::CSEL_EXT;
  assign shifting    = serial_on & (port_mode_a != cssp_pkg::PM_CONT);
  assign cont_active = serial_on & ~ext_sel & ~shifting
                     & (state == cssp_pkg::ST_CLK_WAIT);

  always_comb
  begin
    unique case (mode.clock_select)
      3'h0:    half_sel = cssp_pkg::HALF_DIV0;
      3'h1:    half_sel = cssp_pkg::HALF_DIV1;
      3'h2:    half_sel = cssp_pkg::HALF_DIV2;
      3'h3:    half_sel = cssp_pkg::HALF_DIV3;
      3'h4:    half_sel = cssp_pkg::HALF_DIV4;
      3'h5:    half_sel = cssp_pkg::HALF_DIV5;
      default: half_sel = cssp_pkg::HALF_SYS;
    endcase
  end

  //--------------------------------------------------------------------
  // Clock edge events
  //--------------------------------------------------------------------
  assign gen_tick = (gen_run | cont_active) & (half_cnt == 12'h001);
  assign sck_fall = ext_sel ? (serial_on & sck_prev & ~sck_in)
                            : (gen_tick & sck_int);
  assign sck_rise = ext_sel ? (serial_on & ~sck_prev & sck_in)
                            : (gen_tick & ~sck_int);
  assign wrap     = shifting & sck_rise & ~mode_wr & ~pm_change
                  & ~start_cmd & (state == cssp_pkg::ST_TRANSFER)
                  & (bit_count == cssp_pkg::LAST_BIT);
  assign abort    = (mode_wr | start_cmd)
                  & (state == cssp_pkg::ST_TRANSFER);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sck_prev <= 1'b1;
    else if (clk_en)
      sck_prev <= sck_in;
  end

  //--------------------------------------------------------------------
  // Mode register with delayed update
  //--------------------------------------------------------------------
  // write-only, cleared by reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode      <= cssp_pkg::MODE_RESET;
      mode_pend <= cssp_pkg::MODE_RESET;
      mode_dly  <= 2'h0;
    end
    else if (clk_en)
    begin
      if (mode_wr)
      begin
        mode_pend <= wb_dat_i[3:0];
        mode_dly  <= cssp_pkg::MODE_DELAY;
      end
      else if (mode_dly != 2'h0)
      begin
        mode_dly <= mode_dly - 2'h1;
        if (mode_dly == 2'h1)
          mode <= mode_pend;
      end
    end
  end

  //--------------------------------------------------------------------
  // Port mode and plain port bit
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_mode_a <= cssp_pkg::PORT_MODE_RESET;
      port_out    <= 1'b0;
      port_dir    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr && idx == cssp_pkg::IDX_PORT_MODE)
        port_mode_a <= wb_dat_i[1:0];
      if (wr && idx == cssp_pkg::IDX_PORT_DATA)
      begin
        port_out <= wb_dat_i[cssp_pkg::PDATA_OUT_BIT];
        port_dir <= wb_dat_i[cssp_pkg::PDATA_DIR_BIT];
      end
    end
  end

  //--------------------------------------------------------------------
  // Operating state
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state <= cssp_pkg::ST_WAIT_START;
    else if (clk_en)
    begin
      if (mode_wr || pm_change)
        state <= cssp_pkg::ST_WAIT_START;
      else if (start_cmd)
        state <= cssp_pkg::ST_CLK_WAIT;
      else
      begin
        unique case (state)
          cssp_pkg::ST_WAIT_START:
            state <= cssp_pkg::ST_WAIT_START;
          cssp_pkg::ST_CLK_WAIT:
            if (shifting && sck_fall)
              state <= cssp_pkg::ST_TRANSFER;
          cssp_pkg::ST_TRANSFER:
            if (wrap)
            begin
              if (ext_sel)
                state <= cssp_pkg::ST_CLK_WAIT;
              else
                state <= cssp_pkg::ST_WAIT_START;
            end
          default:
            state <= cssp_pkg::ST_WAIT_START;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Octal bit counter
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      bit_count <= 3'h0;
    else if (clk_en)
    begin
      if (mode_wr || pm_change || start_cmd)
        bit_count <= 3'h0;
      else if (shifting && sck_rise
               && state == cssp_pkg::ST_TRANSFER)
        bit_count <= bit_count + 3'h1;
    end
  end

  //--------------------------------------------------------------------
  // Shift register and serial output
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= cssp_pkg::SHIFT_RESET;
      so_q      <= 1'b1;
    end
    else if (clk_en)
    begin
      if (wr && idx == cssp_pkg::IDX_SHIFT_LO)
        shift_reg[3:0] <= wb_dat_i[3:0];
      else if (wr && idx == cssp_pkg::IDX_SHIFT_HI)
        shift_reg[7:4] <= wb_dat_i[3:0];
      else if (!mode_wr && !pm_change && shifting
               && state != cssp_pkg::ST_WAIT_START)
      begin
        if (sck_fall)
        begin
          so_q      <= shift_reg[0];
          shift_reg <= {shift_reg[7], shift_reg[7:1]};
        end
        else if (sck_rise && port_mode_a[1])
          shift_reg[7] <= si_in;
      end
    end
  end

  //--------------------------------------------------------------------
  // Internal clock generator
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_int  <= 1'b1;
      half_cnt <= cssp_pkg::HALF_SYS;
      gen_run  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (mode_wr || pm_change || !serial_on || ext_sel)
      begin
        sck_int  <= 1'b1;
        half_cnt <= half_sel;
        gen_run  <= 1'b0;
      end
      else if (start_cmd)
      begin
        sck_int  <= 1'b1;
        half_cnt <= half_sel;
        gen_run  <= shifting;
      end
      else if (gen_run || cont_active)
      begin
        if (gen_tick)
        begin
          half_cnt <= half_sel;
          sck_int  <= ~sck_int;
          if (wrap)
            gen_run <= 1'b0;
        end
        else
          half_cnt <= half_cnt - 12'h001;
      end
    end
  end

  //--------------------------------------------------------------------
  // Serial interrupt request flag
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      serial_irq <= 1'b0;
    else if (clk_en)
    begin
      if (wrap || abort)
        serial_irq <= 1'b1;
      else if (clear_cmd)
        serial_irq <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Pin drivers
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pins <= '{sck_out: 1'b1, sck_oe: 1'b0, so_out: 1'b1, so_oe: 1'b0};
    else if (clk_en)
    begin
      // plain port bit or serial clock
      pins.sck_out <= serial_on ? sck_int : port_out;
      pins.sck_oe  <= serial_on ? ~ext_sel : port_dir;
      pins.so_out  <= so_q;
      pins.so_oe   <= shifting & port_mode_a[0];
    end
  end

  //--------------------------------------------------------------------
  // Wishbone read data and acknowledge
  //--------------------------------------------------------------------
  always_comb
  begin
    next_dat = 32'h0000_0000;
    unique case (idx)
      cssp_pkg::IDX_SHIFT_LO:  next_dat[3:0] = shift_reg[3:0];
      cssp_pkg::IDX_SHIFT_HI:  next_dat[3:0] = shift_reg[7:4];
      cssp_pkg::IDX_PORT_MODE: next_dat[1:0] = port_mode_a;
      cssp_pkg::IDX_CTRL:
        next_dat[5:0] = {bit_count, state, serial_irq};
      cssp_pkg::IDX_PORT_DATA:
        next_dat[2:0] = {sck_in, port_dir, port_out};
      default:                 next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= next_dat;
    end
  end

endmodule : cssp_port

// ===== inc/cssp_pkg.sv
/*
  Constants, types and the register map of the clocked serial shift port.
  Assumes a 32-bit classic Wishbone slave: each register sits in one word,
  byte address = register index * 4, narrow data in the low bits.
*/
// Contract
// - Start clears bit counter, starts operation
// - Counter counts from fall, increments on rise
// - Wrap or counter-reset abort sets request flag; a port-mode change abort clears the counter but does not set it
// - Pin function bit and port mode select mode
// - Mode change enters wait-start; clocks ignored there
// - Start in wait-start moves to clock-wait
// - First fall in clock-wait enters transfer, shifts
// - Continuous clock mode stays in clock-wait
// - External: eight clocks return to clock-wait, flag
// - Internal: eight clocks return to wait-start, flag
// - Internal clock starts on start, exactly eight
// - Extra clocks cycle transfer, clock-wait, transfer
// - Mode write clears counter, aborts, sets flag
// - Mode contents apply two cycles after write
// - Mode register: four bits, write-only, reset zero
// - Shift register accessed as two nibbles
// - Output LSB first on fall, input on rise
// - Clock select: prescaler, system clock, external
package cssp_pkg;

  //--------------------------------------------------------------------
  // Register indices (byte address is index times four)
  //--------------------------------------------------------------------
  localparam logic [9:0] IDX_MODE      = 10'h005;
  localparam logic [9:0] IDX_SHIFT_LO  = 10'h006;
  localparam logic [9:0] IDX_SHIFT_HI  = 10'h007;
  localparam logic [9:0] IDX_PORT_MODE = 10'h010;
  localparam logic [9:0] IDX_CTRL      = 10'h011;
  localparam logic [9:0] IDX_PORT_DATA = 10'h012;

  //--------------------------------------------------------------------
  // Fields and reset values
  //--------------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned PDATA_OUT_BIT  = 0;
  localparam int unsigned PDATA_DIR_BIT  = 1;
  localparam logic [3:0]  MODE_RESET     = 4'h0;
  localparam logic [1:0]  PORT_MODE_RESET = 2'h0;
  localparam logic [7:0]  SHIFT_RESET    = 8'h00;
  localparam logic [1:0]  MODE_DELAY     = 2'h2;
  localparam logic [2:0]  LAST_BIT       = 3'h7;

  //--------------------------------------------------------------------
  // Modes and clock selection
  //--------------------------------------------------------------------
  localparam logic [1:0] PM_CONT = 2'h0;
  localparam logic [1:0] PM_TX   = 2'h1;
  localparam logic [1:0] PM_RX   = 2'h2;
  localparam logic [1:0] PM_TXRX = 2'h3;
  localparam logic [2:0] CSEL_SYS = 3'h6;
  localparam logic [2:0] CSEL_EXT = 3'h7;

  // Half periods in mclk cycles for dividers 4096,1024,256,64,16,4,2
  localparam logic [11:0] HALF_DIV0 = 12'h800;
  localparam logic [11:0] HALF_DIV1 = 12'h200;
  localparam logic [11:0] HALF_DIV2 = 12'h080;
  localparam logic [11:0] HALF_DIV3 = 12'h020;
  localparam logic [11:0] HALF_DIV4 = 12'h008;
  localparam logic [11:0] HALF_DIV5 = 12'h002;
  localparam logic [11:0] HALF_SYS  = 12'h001;

  //--------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT_START = 2'b00,
    ST_CLK_WAIT   = 2'b01,
    ST_TRANSFER   = 2'b10
  } cssp_state_t;

  typedef struct packed {
    logic       pin_function_bit;
    logic [2:0] clock_select;
  } cssp_mode_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic so_out;
    logic so_oe;
  } cssp_pins_t;

endpackage : cssp_pkg

// ===== verification/cssp_peer.sv
/*
  External clock-synchronous serial peer.
  Assumes the shared clock line level is resolved by the bench.
*/
`timescale 1ns/1ps
module cssp_peer
(
  // Clock
  input  wire logic       mclk,
  // Serial lines
  input  wire logic       sck,
  input  wire logic       so,
  output logic            si,
  // Frame control and data
  input  wire logic       frst,
  input  wire logic [7:0] tx,
  output logic      [7:0] got
);
  logic       prev_sck;
  logic [2:0] bit_idx;

  always_ff @(posedge mclk)
  begin
    prev_sck <= sck;
    if (frst)
    begin
      si      <= 1'b1;
      bit_idx <= 3'h0;
      got     <= 8'h00;
    end
    else if (prev_sck && !sck)
      si <= tx[bit_idx];
    // Sample on rise, then let data wander
    else if (!prev_sck && sck)
    begin
      got     <= {so, got[7:1]};
      bit_idx <= bit_idx + 3'h1;
      si      <= ~si;
    end
  end
endmodule : cssp_peer

// ===== verification/cssp_port_checker.sv
/*
  Bus and flag assertions of the serial shift port.
  Assumes a single mclk domain with reset_n active low.
*/
`timescale 1ns/1ps
module cssp_port_checker
(
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  // Register bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [11:0]          wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // Pins and flag
  input wire logic                 sck_in,
  input wire logic                 si_in,
  input wire cssp_pkg::cssp_pins_t pins,
  input wire logic                 serial_irq
);
  //--------------------------------------------------------------------
  // Helpers and properties
  //--------------------------------------------------------------------
  logic       take;
  logic [9:0] idx;
  logic       known;
  assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  assign idx   = wb_adr_i[11:2];
  assign known = idx inside {cssp_pkg::IDX_SHIFT_LO, cssp_pkg::IDX_SHIFT_HI,
    cssp_pkg::IDX_PORT_MODE, cssp_pkg::IDX_CTRL, cssp_pkg::IDX_PORT_DATA};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_ack_follow: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> $past(take && !wb_we_i))
    else $error("read data changed without read");
  a_mode_wo: assert property (wb_ack_o && $past(take && !wb_we_i &&
    idx == cssp_pkg::IDX_MODE) |-> wb_dat_o == 32'h0)
    else $error("mode register readable");
  a_unmapped_zero: assert property (wb_ack_o && $past(take && !wb_we_i &&
    !known) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_nibble_width: assert property (wb_ack_o && $past(take && !wb_we_i &&
    (idx == cssp_pkg::IDX_SHIFT_LO || idx == cssp_pkg::IDX_SHIFT_HI))
    |-> wb_dat_o[31:4] == 28'h0)
    else $error("shift nibble wider than four bits");
  a_irq_sticky: assert property (serial_irq && !(take && wb_we_i &&
    wb_sel_i[0] && idx == cssp_pkg::IDX_CTRL && wb_dat_i[1]) |=> serial_irq)
    else $error("flag dropped without clear");
  a_en_freeze: assert property (!clk_en |=> $stable(wb_ack_o) &&
    $stable(serial_irq) && $stable(pins))
    else $error("state moved while disabled");
endmodule : cssp_port_checker

bind cssp_port cssp_port_checker i_cssp_port_checker
(
  .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sck_in(sck_in), .si_in(si_in), .pins(pins),
  .serial_irq(serial_irq)
);

// ===== verification/cssp_port_tb.sv
/*
  Self-checking bench of the serial shift port over classic Wishbone.
  Assumes the package register map and a peer model on the serial pins.
*/
`timescale 1ns/1ps
module cssp_port_tb;
  logic                 mclk, reset_n, clk_en, cyc, stb, we, ack, irq;
  logic                 si, sck_w, ext_sck, frst;
  logic [11:0]          adr;
  logic [31:0]          dat, rdat, q;
  logic [7:0]           tx, got;
  cssp_pkg::cssp_pins_t pins;
  int                   fail_count, n_checks, c, h, t, f;

  assign sck_w = pins.sck_oe ? pins.sck_out : ext_sck;

  cssp_port i_cssp_port (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sck_in(sck_w), .si_in(si), .pins(pins), .serial_irq(irq));
  cssp_peer i_cssp_peer (.mclk(mclk), .sck(sck_w),
    .so(pins.so_oe ? pins.so_out : ~pins.so_out),
    .si(si), .frst(frst), .tx(tx), .got(got));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  //--------------------------------------------------------------------
  // Tasks
  //--------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= d;
    @(posedge mclk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
    begin
      fail_count++;
      give_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    wb(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [31:0] e, string n);
    wb(1'b0, i, 32'h0);
    chk(n, e, q);
  endtask : rd

  task automatic run(input int lim, input bit to_irq);
    logic p;
    t = 0;
    f = 0;
    p = pins.sck_out;
    while (t < lim && !(to_irq && irq === 1'b1))
    begin
      @(posedge mclk);
      t++;
      if (p && !pins.sck_out)
        f++;
      p = pins.sck_out;
    end
    if (to_irq && t >= lim)
    begin
      fail_count++;
      give_verdict();
    end
  endtask : run

  task automatic ext(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge mclk);
      ext_sck <= 1'b0;
      repeat (3) @(posedge mclk);
      ext_sck <= 1'b1;
    end
  endtask : ext

  task automatic frame(input logic [7:0] d, input logic [7:0] p);
    wr(cssp_pkg::IDX_SHIFT_LO, {28'h0, d[3:0]});
    wr(cssp_pkg::IDX_SHIFT_HI, {28'h0, d[7:4]});
    tx <= p;
    frst <= 1'b1;
    @(posedge mclk);
    frst <= 1'b0;
    wr(cssp_pkg::IDX_CTRL, 32'h2);
  endtask : frame

  //--------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------
  initial
  begin
    {reset_n, cyc, stb, we, adr, dat, tx} = '0;
    {clk_en, ext_sck, frst} = 3'b111;
    fail_count = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(cssp_pkg::IDX_MODE, 32'h0, "mode_rd");
    rd(cssp_pkg::IDX_CTRL, 32'h0, "ctrl_rst");
    rd(10'h3FF, 32'h0, "unmapped");
    chk("so_idle", 1, pins.so_out);
    wr(cssp_pkg::IDX_PORT_DATA, 32'h3);
    @(posedge mclk);
    chk("port_oe", 1, pins.sck_oe);
    wr(cssp_pkg::IDX_PORT_DATA, 32'h2);
    @(posedge mclk);
    chk("port_lvl", 0, pins.sck_out);
    rd(cssp_pkg::IDX_PORT_DATA, 32'h2, "port_rd");
    wr(cssp_pkg::IDX_PORT_DATA, 32'h0);
    wr(cssp_pkg::IDX_PORT_MODE, 32'h3);
    for (c = 0; c < 7; c++)
    begin
      wr(cssp_pkg::IDX_MODE, 32'h8 | c);
      frame(8'hA5, 8'hC3);
      wr(cssp_pkg::IDX_CTRL, 32'h1);
      h = (c == 6) ? 1 : (2048 >> (2 * c));
      run(40000, 1'b1);
      chk("pulse_time", 1, t >= 16 * h - 4 && t <= 16 * h + 6);
      chk("pulse_count", 8, f);
      rd(cssp_pkg::IDX_CTRL, 32'h1, "int_done");
      if (c == 4)
      begin
        chk("peer_rx", 8'hA5, got);
        rd(cssp_pkg::IDX_SHIFT_LO, 32'h3, "rx_lo");
        rd(cssp_pkg::IDX_SHIFT_HI, 32'hC, "rx_hi");
      end
    end
    chk("so_oe_txrx", 1, pins.so_oe);
    wr(cssp_pkg::IDX_MODE, 32'hF);
    ext(3);
    frame(8'h96, 8'h3C);
    rd(cssp_pkg::IDX_CTRL, 32'h0, "ignored");
    wr(cssp_pkg::IDX_CTRL, 32'h1);
    rd(cssp_pkg::IDX_CTRL, 32'h2, "clk_wait");
    ext(8);
    rd(cssp_pkg::IDX_CTRL, 32'h3, "ext_done");
    chk("peer_ext", 8'h96, got);
    rd(cssp_pkg::IDX_SHIFT_LO, 32'hC, "ext_lo");
    wr(cssp_pkg::IDX_CTRL, 32'h2);
    ext(9);
    rd(cssp_pkg::IDX_CTRL, 32'hD, "extra_clk");
    wr(cssp_pkg::IDX_CTRL, 32'h2);
    wr(cssp_pkg::IDX_MODE, 32'hE);
    rd(cssp_pkg::IDX_CTRL, 32'h1, "abort");
    wr(cssp_pkg::IDX_PORT_MODE, 32'h0);
    wr(cssp_pkg::IDX_CTRL, 32'h2);
    wr(cssp_pkg::IDX_CTRL, 32'h1);
    run(40, 1'b0);
    chk("cont_run", 1, f >= 16);
    chk("so_oe_cont", 0, pins.so_oe);
    clk_en <= 1'b0;
    repeat (4) @(posedge mclk);
    clk_en <= 1'b1;
    rd(cssp_pkg::IDX_CTRL, 32'h2, "cont_state");
    wr(cssp_pkg::IDX_PORT_MODE, 32'h1);
    @(posedge mclk);
    chk("so_oe_tx", 1, pins.so_oe);
    wr(cssp_pkg::IDX_PORT_MODE, 32'h2);
    rd(cssp_pkg::IDX_PORT_MODE, 32'h2, "pm_rd");
    chk("so_oe_rx", 0, pins.so_oe);
    give_verdict();
  end
endmodule : cssp_port_tb
